// >>> pkg/ufg_pkg.sv
/*
  Shared constants and types for the user flash / programming contention guard.
  Assumes a single 250 MHz clock domain and a 32-bit AXI4-Lite register port.
*/
package ufg_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLAMP_SEL = 8'h08;
  localparam logic [7:0] OFS_CLAMP_VAL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_RTP_BIT = 0;
  localparam int unsigned CTRL_CLAMP_BIT = 1;
  localparam int unsigned CTRL_WRAP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_SESSION_BIT = 2;
  localparam int unsigned ST_WRPEND_BIT = 3;
  localparam int unsigned ST_TAPRST_BIT = 4;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_START_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT = 1;
  localparam int unsigned IRQ_FAIL_BIT = 2;
  localparam int unsigned IRQ_CONTEND_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Bus answers and TAP timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [2:0] TLR_EDGES = 3'h5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  localparam int unsigned FLASH_DATA_W = 16;

  typedef enum logic [2:0] {
    UFG_OP_NONE = 3'h0,
    UFG_OP_READ = 3'h1,
    UFG_OP_WRITE = 3'h2,
    UFG_OP_ERASE = 3'h3,
    UFG_OP_SHIFT_ADDR = 3'h4,
    UFG_OP_SHIFT_DATA = 3'h5
  } ufg_op_e;

  typedef struct packed {
    ufg_op_e op;
    logic [FLASH_DATA_W-1:0] data;
  } ufg_flash_req_s;

  typedef struct packed {
    logic wrapped;
    logic clamp_en;
    logic rtp_en;
  } ufg_ctrl_s;

  typedef enum logic [1:0] {
    UFG_SES_IDLE = 2'h0,
    UFG_SES_ACTIVE = 2'h1
  } ufg_ses_e;

endpackage : ufg_pkg

// >>> rtl/ufg_flash_gate.sv
/*
  One-stage request register between user logic and the user flash array,
  stopping new operations while real-time programming is busy in wrapped mode.
  Assumes the array follows a valid/ready handshake on the same clock.
*/
`timescale 1ns/100ps
module ufg_flash_gate (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic wrapped,
  input wire logic busy,
  // User side
  input wire ufg_pkg::ufg_flash_req_s user_req,
  input wire logic user_req_valid,
  output logic user_req_ready,
  // Array side
  output ufg_pkg::ufg_flash_req_s flash_req,
  output logic flash_req_valid,
  input wire logic flash_req_ready
);

  logic stage_valid_q;
  ufg_pkg::ufg_flash_req_s stage_q;
  logic block;

  // ----------------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------------
  // Bare mode leaves gating to the user, so busy is ignored there
  assign block = wrapped && busy;
  assign flash_req_valid = stage_valid_q && !block;
  assign user_req_ready = !block && (!stage_valid_q || flash_req_ready);
  assign flash_req = stage_q;

  // Stage occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_valid_q <= 1'h0;
    end else if (user_req_valid && user_req_ready) begin
      stage_valid_q <= 1'h1;
    end else if (flash_req_valid && flash_req_ready) begin
      stage_valid_q <= 1'h0;
    end
  end

  // Stage payload, held while an op waits out a busy period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= '0;
    end else if (user_req_valid && user_req_ready) begin
      stage_q <= user_req;
    end
  end

  AST_GATE_NO_ISSUE: assert property (@(posedge aclk) disable iff (!aresetn)
    (wrapped && busy) |-> (!flash_req_valid && !user_req_ready))
    else $error("flash op issued while programming busy");

  AST_GATE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (stage_valid_q && !(flash_req_valid && flash_req_ready)) |=> (stage_valid_q && $stable(stage_q)))
    else $error("staged flash op lost or changed");

endmodule : ufg_flash_gate

// >>> rtl/ufg_top.sv
/*
  Contention guard between user flash access and programming sessions, with
  TAP reset tracking, pin control during programming and an AXI4-Lite port.
  Assumes all pin inputs, including tck, are synchronous to aclk.
*/
//
// Contract
// - A flash read in progress never delays the start of a session.
// - The busy output is high for as long as a real-time programming session runs.
// - Wrapped interface variants stop flash operations on busy; the bare one does not.
// - After its initial load from prog_complete_init, the complete flag is set only at the end of a successful session.
// - Outside a session, user pins drive outputs only while the complete flag is set.
// - By default every user pin is tri-stated with a weak pull-up during a session.
// - With the clamp feature, each selected pin holds its configured level all session.
// - Without core power the JTAG logic is inactive and the test output is tri-stated.
// - TDI and TMS get weak pull-ups, TCK a weak pull-down, TDO neither.
// - While TMS is held high the TAP stays in test-logic-reset despite TCK pulses.
`timescale 1ns/100ps
module ufg_top #(
  parameter int unsigned NPIN = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ufg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ufg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // JTAG pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe_n,
  output logic tdi_pullup_en,
  output logic tms_pullup_en,
  output logic tck_pulldown_en,
  input wire logic core_pwr_good,
  // Programming engine
  input wire logic prog_start,
  input wire logic prog_end_ok,
  input wire logic prog_end_fail,
  input wire logic prog_complete_init,
  output logic realtime_prog_busy,
  output logic prog_complete_flag,
  // User flash access
  input wire ufg_pkg::ufg_flash_req_s user_req,
  input wire logic user_req_valid,
  output logic user_req_ready,
  output ufg_pkg::ufg_flash_req_s flash_req,
  output logic flash_req_valid,
  input wire logic flash_req_ready,
  input wire logic flash_wr_busy,
  input wire logic flash_rd_busy,
  // User pins
  input wire logic [NPIN-1:0] user_pin_o,
  input wire logic [NPIN-1:0] user_pin_oe_n,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_n,
  output logic [NPIN-1:0] pin_pullup_en
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ufg_pkg::ufg_ctrl_s ctrl_q;
  logic [NPIN-1:0] clamp_sel_q;
  logic [NPIN-1:0] clamp_val_q;
  logic [ufg_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ufg_pkg::IRQ_W-1:0] irq_stat_d;
  logic [ufg_pkg::IRQ_W-1:0] irq_mask_q;
  logic [ufg_pkg::IRQ_W-1:0] irq_set;
  logic [ufg_pkg::IRQ_W-1:0] irq_clr;
  logic aw_have_q;
  logic w_have_q;
  logic [ufg_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] wmask;
  logic do_write;
  logic [31:0] rdata_d;
  logic rhit;
  ufg_pkg::ufg_ses_e ses_q;
  logic busy_q;
  logic done_q;
  logic init_q;
  logic start_ok;
  logic tck_q;
  logic tck_rise;
  logic [2:0] tms_cnt_q;
  logic tap_reset_q;
  logic bypass_q;
  logic session_q;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  // Address and data may come in either order; no new beat until B is taken
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_write = aw_have_q && w_have_q;

  // Capture of the two write halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'h0;
      w_have_q <= 1'h0;
      awaddr_q <= '0;
      wdata_q <= ufg_pkg::WORD_RESET;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'h1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'h1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'h0;
      end
    end
  end

  // Byte-lane mask from the write strobes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  end

  // Write response; unmapped offsets answer DECERR and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= ufg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'h1;
      case (awaddr_q)
        ufg_pkg::OFS_CTRL, ufg_pkg::OFS_STATUS, ufg_pkg::OFS_CLAMP_SEL,
        ufg_pkg::OFS_CLAMP_VAL, ufg_pkg::OFS_IRQ_STAT, ufg_pkg::OFS_IRQ_MASK: begin
          s_axi_bresp <= ufg_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= ufg_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Control, clamp select/value and mask; STATUS writes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ufg_pkg::CTRL_RESET;
      clamp_sel_q <= '0;
      clamp_val_q <= '0;
      irq_mask_q <= ufg_pkg::IRQ_RESET;
    end else if (do_write) begin
      case (awaddr_q)
        ufg_pkg::OFS_CTRL: begin
          ctrl_q <= (ctrl_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
        end
        ufg_pkg::OFS_CLAMP_SEL: begin
          clamp_sel_q <= (clamp_sel_q & ~wmask[NPIN-1:0]) | (wdata_q[NPIN-1:0] & wmask[NPIN-1:0]);
        end
        ufg_pkg::OFS_CLAMP_VAL: begin
          clamp_val_q <= (clamp_val_q & ~wmask[NPIN-1:0]) | (wdata_q[NPIN-1:0] & wmask[NPIN-1:0]);
        end
        ufg_pkg::OFS_IRQ_MASK: begin
          irq_mask_q <= (irq_mask_q & ~wmask[3:0]) | (wdata_q[3:0] & wmask[3:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky events, cleared by writing one; a same-cycle event wins
  assign irq_clr = (do_write && awaddr_q == ufg_pkg::OFS_IRQ_STAT) ?
                   (wdata_q[3:0] & wmask[3:0]) : ufg_pkg::IRQ_RESET;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= ufg_pkg::IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = ufg_pkg::WORD_RESET;
    rhit = 1'h1;
    case (s_axi_araddr)
      ufg_pkg::OFS_CTRL: rdata_d[2:0] = ctrl_q;
      ufg_pkg::OFS_STATUS: begin
        rdata_d[ufg_pkg::ST_BUSY_BIT] = busy_q;
        rdata_d[ufg_pkg::ST_DONE_BIT] = done_q;
        rdata_d[ufg_pkg::ST_SESSION_BIT] = session_q;
        rdata_d[ufg_pkg::ST_WRPEND_BIT] = flash_wr_busy;
        rdata_d[ufg_pkg::ST_TAPRST_BIT] = tap_reset_q;
      end
      ufg_pkg::OFS_CLAMP_SEL: rdata_d[NPIN-1:0] = clamp_sel_q;
      ufg_pkg::OFS_CLAMP_VAL: rdata_d[NPIN-1:0] = clamp_val_q;
      ufg_pkg::OFS_IRQ_STAT: rdata_d[3:0] = irq_stat_q;
      ufg_pkg::OFS_IRQ_MASK: rdata_d[3:0] = irq_mask_q;
      default: rhit = 1'h0;
    endcase
  end

  // One read at a time; data is held until rready
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= ufg_pkg::WORD_RESET;
      s_axi_rresp <= ufg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rhit ? ufg_pkg::RESP_OKAY : ufg_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // TAP reset tracking and test output
  // ----------------------------------------------------------------------
  assign tck_rise = tck && !tck_q;
  // Fixed pull controls on the test pins
  assign tdi_pullup_en = 1'h1;
  assign tms_pullup_en = 1'h1;
  assign tck_pulldown_en = 1'h1;

  // Consecutive TMS-high edges reach reset; TMS high keeps it there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_q <= 1'h0;
      tms_cnt_q <= 3'h0;
      tap_reset_q <= 1'h1;
      bypass_q <= 1'h0;
    end else begin
      tck_q <= tck;
      if (!core_pwr_good) begin
        tms_cnt_q <= 3'h0;
        tap_reset_q <= 1'h1;
      end else if (tck_rise) begin
        bypass_q <= tdi;
        if (tms) begin
          if (tms_cnt_q != ufg_pkg::TLR_EDGES) begin
            tms_cnt_q <= tms_cnt_q + 3'h1;
          end
          if (tms_cnt_q >= ufg_pkg::TLR_EDGES - 3'h1) begin
            tap_reset_q <= 1'h1;
          end
        end else begin
          tms_cnt_q <= 3'h0;
          tap_reset_q <= 1'h0;
        end
      end
    end
  end
  // Test output is only driven with power and the TAP out of reset
  assign tdo_o = bypass_q;
  assign tdo_oe_n = tap_reset_q;

  // ----------------------------------------------------------------------
  // Programming session
  // ----------------------------------------------------------------------
  // Start ignores reads in flight; only erase/write matters for contention
  assign start_ok = prog_start && core_pwr_good && !tap_reset_q;
  assign irq_set[ufg_pkg::IRQ_START_BIT] = (ses_q == ufg_pkg::UFG_SES_IDLE) && start_ok;
  assign irq_set[ufg_pkg::IRQ_DONE_BIT] = (ses_q == ufg_pkg::UFG_SES_ACTIVE) && prog_end_ok;
  assign irq_set[ufg_pkg::IRQ_FAIL_BIT] = (ses_q == ufg_pkg::UFG_SES_ACTIVE) && !prog_end_ok &&
                                          (prog_end_fail || !core_pwr_good);
  // A session begun over a running erase/write is flagged, not prevented
  assign irq_set[ufg_pkg::IRQ_CONTEND_BIT] = irq_set[ufg_pkg::IRQ_START_BIT] && flash_wr_busy;

  // Session state, busy and the complete flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ses_q <= ufg_pkg::UFG_SES_IDLE;
      busy_q <= 1'h0;
      done_q <= 1'h0;
      init_q <= 1'h0;
    end else begin
      init_q <= 1'h1;
      case (ses_q)
        ufg_pkg::UFG_SES_IDLE: begin
          if (!init_q) begin
            done_q <= prog_complete_init;
          end
          if (start_ok) begin
            ses_q <= ufg_pkg::UFG_SES_ACTIVE;
            busy_q <= ctrl_q.rtp_en;
            done_q <= 1'h0;
          end
        end
        ufg_pkg::UFG_SES_ACTIVE: begin
          if (prog_end_ok) begin
            ses_q <= ufg_pkg::UFG_SES_IDLE;
            busy_q <= 1'h0;
            done_q <= 1'h1;
          end else if (prog_end_fail || !core_pwr_good) begin
            ses_q <= ufg_pkg::UFG_SES_IDLE;
            busy_q <= 1'h0;
          end
        end
        default: begin
          ses_q <= ufg_pkg::UFG_SES_IDLE;
          busy_q <= 1'h0;
        end
      endcase
    end
  end
  assign realtime_prog_busy = busy_q;
  assign prog_complete_flag = done_q;
  assign session_q = (ses_q == ufg_pkg::UFG_SES_ACTIVE);

  // ----------------------------------------------------------------------
  // User flash gating
  // ----------------------------------------------------------------------
  ufg_flash_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .wrapped(ctrl_q.wrapped),
    .busy(busy_q),
    .user_req(user_req),
    .user_req_valid(user_req_valid),
    .user_req_ready(user_req_ready),
    .flash_req(flash_req),
    .flash_req_valid(flash_req_valid),
    .flash_req_ready(flash_req_ready)
  );

  // ----------------------------------------------------------------------
  // User pin control
  // ----------------------------------------------------------------------
  // Registered per pin; takes effect one cycle after the session edge
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_o[i] <= 1'h0;
        pin_oe_n[i] <= 1'h1;
        pin_pullup_en[i] <= 1'h0;
      end else if (session_q && ctrl_q.clamp_en && clamp_sel_q[i]) begin
        pin_o[i] <= clamp_val_q[i];
        pin_oe_n[i] <= 1'h0;
        pin_pullup_en[i] <= 1'h0;
      end else if (session_q) begin
        pin_o[i] <= 1'h0;
        pin_oe_n[i] <= 1'h1;
        pin_pullup_en[i] <= 1'h1;
      end else if (done_q) begin
        pin_o[i] <= user_pin_o[i];
        pin_oe_n[i] <= user_pin_oe_n[i];
        pin_pullup_en[i] <= 1'h0;
      end else begin
        pin_o[i] <= 1'h0;
        pin_oe_n[i] <= 1'h1;
        pin_pullup_en[i] <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_BUSY_ON_START: assert property (@(posedge aclk) disable iff (!aresetn)
    (!session_q && start_ok && ctrl_q.rtp_en) |=> (busy_q && session_q) [*1] ##0 realtime_prog_busy)
    else $error("busy not raised at real-time session start");

  AST_BUSY_ONLY_SESSION: assert property (@(posedge aclk) disable iff (!aresetn)
    realtime_prog_busy |-> session_q)
    else $error("busy high outside a session");

  AST_READ_NO_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    (!session_q && start_ok && flash_rd_busy) |=> session_q)
    else $error("read in progress delayed session start");

  AST_DONE_ONLY_OK: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(done_q) && $past(init_q)) |-> ($past(session_q) && $past(prog_end_ok)))
    else $error("complete flag set without successful end");

  AST_FAIL_KEEPS_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (session_q && prog_end_fail && !prog_end_ok) |=> (!done_q && !session_q) ##1 !done_q)
    else $error("complete flag set after failed session");

  AST_NO_DRIVE_UNDONE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!done_q && !session_q) |=> (pin_oe_n == {NPIN{1'h1}}))
    else $error("pins driven without complete flag");

  AST_TRISTATE_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    (session_q && !ctrl_q.clamp_en) |=> ((pin_oe_n & pin_pullup_en) == {NPIN{1'h1}}))
    else $error("pins not tri-stated with pull-up in session");

  AST_CLAMP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (session_q && ctrl_q.clamp_en) |=>
      (((pin_o ^ $past(clamp_val_q)) & $past(clamp_sel_q)) == '0) &&
      ((pin_oe_n & $past(clamp_sel_q)) == '0))
    else $error("clamped pin not at its level");

  AST_NO_CORE_NO_TDO: assert property (@(posedge aclk) disable iff (!aresetn)
    !core_pwr_good |=> (tdo_oe_n && tap_reset_q && !session_q))
    else $error("test output driven without core power");

  AST_TMS_KEEPS_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap_reset_q && tms) |=> tap_reset_q)
    else $error("TAP left reset with TMS high");

  AST_PULLS_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (tdi_pullup_en && tms_pullup_en && tck_pulldown_en) [*3])
    else $error("test pin pulls not enabled");

  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before bready");

endmodule : ufg_top

// >>> testbench/ufg_flash_model.sv
/* Behavioural flash array on the gate's array side.
   Assumes the same clock and reset as the guard. */
`timescale 1ns/100ps
module ufg_flash_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Array side
  input wire ufg_pkg::ufg_flash_req_s flash_req,
  input wire logic flash_req_valid,
  output logic flash_req_ready,
  output logic flash_wr_busy,
  output logic flash_rd_busy
);
  logic [3:0] cnt_q;
  logic wr_q;
  // Ready alternates, so some takes stall a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) flash_req_ready <= 1'b0;
    else flash_req_ready <= !flash_req_ready;
  end
  // A taken operation keeps the array busy eight cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 4'h0;
    else if (flash_req_valid && flash_req_ready) cnt_q <= 4'h8;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  // Erase and write count as write work
  always_ff @(posedge aclk) begin
    if (flash_req_valid && flash_req_ready) wr_q <= flash_req.op[1];
  end
  assign flash_wr_busy = (cnt_q != 4'h0) && (wr_q === 1'b1);
  assign flash_rd_busy = (cnt_q != 4'h0) && (wr_q === 1'b0);
endmodule : ufg_flash_model

// >>> testbench/test_ufm_isp_contention_guard.sv
/* Bench for the contention guard: AXI4-Lite tasks, TAP and sessions.
   Assumes the flash model on the array side. */
`timescale 1ns/100ps
module test_ufm_isp_contention_guard;
  logic aclk = 0, aresetn = 0, tck = 0, tms = 0, tdi = 0, core_pwr_good = 1;
  logic prog_start = 0, prog_end_ok = 0, prog_end_fail = 0, prog_complete_init = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, user_req_valid = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, user_pin_o = '0, user_pin_oe_n = '1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arready, s_axi_rvalid, irq, tdo_o, tdo_oe_n, tdi_pullup_en, tms_pullup_en;
  logic tck_pulldown_en, realtime_prog_busy, prog_complete_flag, user_req_ready;
  logic flash_req_valid, flash_req_ready, flash_wr_busy, flash_rd_busy;
  logic [7:0] pin_o, pin_oe_n, pin_pullup_en;
  ufg_pkg::ufg_flash_req_s user_req = '0, flash_req;
  int errors = 0, checked = 0, i;
  logic [2:0] c;
  ufg_top u_dut (.*);
  ufg_flash_model u_mem (.*);
  // 250 MHz clock
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Master holds each channel until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit dn;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 64 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      dn = s_axi_bvalid;
    end
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, ufg_pkg::RESP_OKAY);
    if (!dn) errors++;
    if (!dn) tally_and_finish();
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    bit dn;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 64 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      dn = s_axi_rvalid;
    end
    s_axi_rready <= 0;
    chk("rresp", s_axi_rresp, r);
    chk("rdata", s_axi_rdata, e);
    if (!dn) errors++;
    if (!dn) tally_and_finish();
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      tck <= 1;
      cyc(2);
      @(posedge aclk);
      tck <= 0;
    end
  endtask : pulse
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rdc(ufg_pkg::OFS_STATUS, 32'h10, ufg_pkg::RESP_OKAY);
    rdc(8'hfc, 32'h0, ufg_pkg::RESP_DECERR);
    chk("pulls", {tdi_pullup_en, tms_pullup_en, tck_pulldown_en, tdo_oe_n}, 4'hf);
    pulse(1);
    tms <= 1;
    pulse(6);
    rdc(ufg_pkg::OFS_STATUS, 32'h10, ufg_pkg::RESP_OKAY);
    {tms, tdi} <= 2'h1;
    pulse(1);
    rdc(ufg_pkg::OFS_STATUS, 32'h0, ufg_pkg::RESP_OKAY);
    chk("tdo", {tdo_o, tdo_oe_n}, 2'h2);
    // Core power dip puts the TAP back in reset
    core_pwr_good <= 0;
    @(posedge aclk);
    core_pwr_good <= 1;
    cyc(1);
    chk("tdo", {tdo_o, tdo_oe_n}, 2'h3);
    pulse(1);
    wr(ufg_pkg::OFS_CLAMP_SEL, 32'h0f);
    wr(ufg_pkg::OFS_CLAMP_VAL, 32'h05);
    {user_pin_oe_n, user_pin_o} <= 16'h00a5;
    // Modes: bare busy, wrapped, all features, clamp only
    for (i = 0; i < 4; i++) begin
      c = 3'(i * 3 + 1);
      wr(ufg_pkg::OFS_IRQ_MASK, 32'hf);
      wr(ufg_pkg::OFS_CTRL, {29'h0, c});
      prog_start <= 1;
      @(posedge aclk);
      prog_start <= 0;
      cyc(3);
      chk("busy", {realtime_prog_busy, prog_complete_flag, irq}, {c[0], 2'h1});
      chk("oe", pin_oe_n, c[1] ? 8'hf0 : 8'hff);
      chk("pins", {pin_pullup_en[7:4], pin_o[3:0]}, c[1] ? 8'hf5 : 8'hf0);
      if (c[2]) begin
        @(posedge aclk);
        user_req <= '{ufg_pkg::UFG_OP_READ, 16'h00a5};
        user_req_valid <= 1;
        #1 chk("ready", user_req_ready, !c[0]);
        @(posedge aclk);
        user_req_valid <= 0;
        #1 chk("freq", {flash_req_valid, flash_req},
               {!c[0], ufg_pkg::UFG_OP_READ, 16'h00a5});
      end
      @(posedge aclk);
      {prog_end_ok, prog_end_fail} <= i[0] ? 2'h2 : 2'h1;
      @(posedge aclk);
      {prog_end_ok, prog_end_fail} <= 2'h0;
      cyc(3);
      chk("end", {prog_complete_flag, realtime_prog_busy}, {i[0], 1'b0});
      chk("oe", {pin_oe_n, pin_o}, i[0] ? 16'h00a5 : 16'hff00);
      rdc(ufg_pkg::OFS_IRQ_STAT, i[0] ? 32'h3 : 32'h5, ufg_pkg::RESP_OKAY);
      wr(ufg_pkg::OFS_IRQ_MASK, 32'h0);
      cyc(1);
      chk("irq", irq, 0);
      wr(ufg_pkg::OFS_IRQ_STAT, 32'hf);
      rdc(ufg_pkg::OFS_IRQ_STAT, 32'h0, ufg_pkg::RESP_OKAY);
      $display("test %0d done", i);
    end
    // Start over a running write is flagged; over a read it is not
    for (i = 0; i < 2; i++) begin
      user_req.op <= ufg_pkg::ufg_op_e'(i[0] ? ufg_pkg::UFG_OP_READ : ufg_pkg::UFG_OP_WRITE);
      user_req_valid <= 1;
      @(posedge aclk);
      user_req_valid <= 0;
      repeat (3) @(posedge aclk);
      prog_start <= 1;
      @(posedge aclk);
      prog_start <= 0;
      rdc(ufg_pkg::OFS_STATUS, i[0] ? 32'h4 : 32'hc, ufg_pkg::RESP_OKAY);
      @(posedge aclk);
      prog_end_ok <= 1;
      @(posedge aclk);
      prog_end_ok <= 0;
      rdc(ufg_pkg::OFS_IRQ_STAT, i[0] ? 32'h3 : 32'hb, ufg_pkg::RESP_OKAY);
      wr(ufg_pkg::OFS_IRQ_STAT, 32'hf);
      $display("test %0d done", i + 4);
    end
    tally_and_finish();
  end
endmodule : test_ufm_isp_contention_guard
